// ===== design/dacw_byte_shifter.sv
// byte shifter: eight clocks, idle low, data set on rise, held at fall
module dacw_byte_shifter #(
    parameter bit LSB_FIRST = 1'b0
) (
    input wire logic clk_in,        // system clock
    input wire logic rstn_in,       // async reset, active low
    input wire logic start_in,      // pulse: load byte and begin
    input wire logic [7:0] byte_in, // byte to send
    input wire logic tick_in,       // half-period tick
    output logic busy_out,          // byte in progress
    output logic done_out,          // pulse with the eighth falling edge
    output logic fall_out,          // pulse on each falling edge
    output logic sclk_out,          // serial clock, idle low
    output logic sdo_out            // serial data
);

    logic [7:0] sh_reg;
    logic [2:0] cnt_reg;

    // clock phase: data changes on the rising edge so that it stands
    // a whole half period before the falling edge samples it
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sh_reg <= 8'h00;
            cnt_reg <= 3'h0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            fall_out <= 1'b0;
            sclk_out <= 1'b0;
            sdo_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            fall_out <= 1'b0;
            if (start_in && !busy_out) begin
                sh_reg <= byte_in;
                cnt_reg <= 3'h0;
                busy_out <= 1'b1;
                sclk_out <= 1'b0;
            end else if (busy_out && tick_in) begin
                if (!sclk_out) begin
                    sclk_out <= 1'b1;
                    if (LSB_FIRST) begin
                        sdo_out <= sh_reg[0];
                        sh_reg <= {1'b0, sh_reg[7:1]};
                    end else begin
                        sdo_out <= sh_reg[7];
                        sh_reg <= {sh_reg[6:0], 1'b0};
                    end
                end else begin
                    sclk_out <= 1'b0;
                    fall_out <= 1'b1;
                    cnt_reg <= cnt_reg + 3'h1;
                    if (cnt_reg == 3'h7) begin
                        busy_out <= 1'b0; // [R5]
                        done_out <= 1'b1;
                    end
                end
            end
        end
    end

endmodule

// ===== design/dacw_host.sv
// host controller: loads 16-bit words into the octal dac over its pins
//
// Operation
// [R1] host lowers frame sync from a port line before shifting a word
// [R2] frame sync comes from controller state, not the serial shifter
// [R3] data stands stable at each falling serial clock edge in the frame
// [R4] each word goes as two bytes with frame sync low between them
// [R5] each byte gives exactly eight falling edges, sixteen per word
// [R6] frame sync returns high after the second byte ends
// [R7] device takes the word most significant bit first
// [R8] an lsb-first shifter gets each byte reversed beforehand
// [R9] serial clock idles low, data valid at the falling edge
// [R10] load strobe and clear are driven from plain port outputs
// [R11] load strobe may pulse low after each word for an update
// [R12] or eight words first, then one load strobe updates all outputs
// [R13] device ignores extra clocks until the next frame sync fall
// [R14] bit 3 of the word must match the device address pin
// [R15] bits 0 to 2 select which channel input latch is written
// [R16] load strobe low copies all input latches to output latches
// [R17] clear low zeros output latches, input latches keep their data
// [R18] load strobe never pulses while a word is being shifted
module dacw_host #(
    parameter int SCLK_HALF = dacw_pkg::SCLK_HALF_DEF,
    parameter bit LSB_FIRST_SHIFTER = 1'b0
) (
    input wire logic clk_in,                    // system clock, 50 MHz
    input wire logic rstn_in,                   // async reset, active low
    input wire logic cmd_valid_in,              // command offered
    input wire dacw_pkg::dacw_cmd_t cmd_in,     // command
    output logic cmd_ready_out,                 // command taken when high
    output logic busy_out,                      // sequence in progress
    output logic [15:0] readback_out,           // word seen on chain output
    output logic readback_valid_out,            // pulse: readback updated
    input wire logic serial_chain_output_in,    // device chain output pin
    output logic frame_sync_n_out,              // frame sync, active low
    output logic serial_shift_clock_out,        // serial clock, idle low
    output logic serial_data_input_out,         // serial data to device
    output logic output_load_strobe_n_out,      // load strobe, active low
    output logic output_clear_n_out             // clear, active low
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_BYTE,
        ST_GAP,
        ST_HOLD,
        ST_LOAD,
        ST_CLEAR,
        ST_RECOVER
    } dacw_state_t;

    localparam int WW = dacw_pkg::WAIT_W;
    localparam int FS_RET_MAX = 64;

    // bit reversal of one byte, for shifters that send lsb first
    function automatic logic [7:0] dacw_rev8(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7 - i];
        end
        return r;
    endfunction

    // wait count from a cycle figure, loaded as count minus one
    function automatic logic [WW-1:0] dacw_wait(input int cyc);
        return WW'(cyc - 1);
    endfunction

    dacw_state_t state_reg, state_next;
    logic [15:0] word_reg, word_next;
    logic [WW-1:0] wait_reg, wait_next;
    logic idx_reg, idx_next;
    logic load_after_reg, load_after_next;
    logic fs_n_reg, fs_n_next;
    logic ld_n_reg, ld_n_next;
    logic clr_n_reg, clr_n_next;
    logic start_reg, start_next;
    logic [7:0] byte_raw;
    logic [7:0] byte_tx;
    logic sh_busy, sh_done, sh_fall, tick;
    logic sclk_w, sdo_w;
    logic chain_s1_reg, chain_s2_reg;
    logic [15:0] rx_reg;
    logic [4:0] fall_cnt_reg;

    assign cmd_ready_out = (state_reg == ST_IDLE);
    assign busy_out = (state_reg != ST_IDLE);

    // byte selection: high byte first so the word leaves msb first
    assign byte_raw = idx_reg ? word_reg[7:0] : word_reg[15:8]; // [R7]
    assign byte_tx = LSB_FIRST_SHIFTER ? dacw_rev8(byte_raw)
                                       : byte_raw; // [R8]

    // next-state logic for the whole sequence
    always_comb begin
        state_next = state_reg;
        word_next = word_reg;
        wait_next = wait_reg;
        idx_next = idx_reg;
        load_after_next = load_after_reg;
        fs_n_next = fs_n_reg;
        ld_n_next = ld_n_reg;
        clr_n_next = clr_n_reg;
        start_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (cmd_valid_in) begin
                    case (cmd_in.kind)
                        dacw_pkg::DACW_CMD_WRITE: begin
                            word_next = 16'h0000;
                            word_next[dacw_pkg::VALUE_LSB +:
                                      dacw_pkg::VALUE_W] = cmd_in.value;
                            word_next[dacw_pkg::ADDR_BIT] =
                                cmd_in.address; // [R14]
                            word_next[dacw_pkg::CHAN_LSB +:
                                      dacw_pkg::CHAN_W] =
                                cmd_in.channel; // [R15]
                            load_after_next = cmd_in.load_after; // [R11]
                            fs_n_next = 1'b0; // [R1] [R2] [R13]
                            wait_next = dacw_wait(dacw_pkg::FS_SETUP_CYC);
                            state_next = ST_SETUP;
                        end
                        dacw_pkg::DACW_CMD_LOAD: begin
                            ld_n_next = 1'b0; // [R12] [R16]
                            wait_next =
                                dacw_wait(dacw_pkg::LOAD_PULSE_CYC);
                            state_next = ST_LOAD;
                        end
                        dacw_pkg::DACW_CMD_CLEAR: begin
                            clr_n_next = 1'b0; // [R10] [R17]
                            wait_next =
                                dacw_wait(dacw_pkg::CLEAR_PULSE_CYC);
                            state_next = ST_CLEAR;
                        end
                        default: begin
                            state_next = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_SETUP: begin
                if (wait_reg == '0) begin
                    idx_next = 1'b0;
                    start_next = 1'b1;
                    state_next = ST_BYTE;
                end else begin
                    wait_next = wait_reg - 1'b1;
                end
            end
            ST_BYTE: begin
                if (sh_done) begin
                    if (!idx_reg) begin
                        // frame sync stays low across the byte gap
                        idx_next = 1'b1; // [R4]
                        wait_next = dacw_wait(dacw_pkg::BYTE_GAP_CYC);
                        state_next = ST_GAP;
                    end else begin
                        wait_next = dacw_wait(dacw_pkg::FS_HOLD_CYC);
                        state_next = ST_HOLD;
                    end
                end
            end
            ST_GAP: begin
                if (wait_reg == '0) begin
                    start_next = 1'b1;
                    state_next = ST_BYTE;
                end else begin
                    wait_next = wait_reg - 1'b1;
                end
            end
            ST_HOLD: begin
                if (wait_reg == '0) begin
                    fs_n_next = 1'b1; // [R6]
                    // load strobe falls on the same edge that closes the frame
                    if (load_after_reg) begin
                        ld_n_next = 1'b0; // [R11] [R18]
                        wait_next = dacw_wait(dacw_pkg::LOAD_PULSE_CYC);
                        state_next = ST_LOAD;
                    end else begin
                        wait_next = dacw_wait(dacw_pkg::RECOVER_CYC);
                        state_next = ST_RECOVER;
                    end
                end else begin
                    wait_next = wait_reg - 1'b1;
                end
            end
            ST_LOAD, ST_CLEAR: begin
                if (wait_reg == '0) begin
                    ld_n_next = 1'b1;
                    clr_n_next = 1'b1;
                    wait_next = dacw_wait(dacw_pkg::RECOVER_CYC);
                    state_next = ST_RECOVER;
                end else begin
                    wait_next = wait_reg - 1'b1;
                end
            end
            ST_RECOVER: begin
                if (wait_reg == '0) begin
                    state_next = ST_IDLE;
                end else begin
                    wait_next = wait_reg - 1'b1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // sequence state
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= ST_IDLE;
            word_reg <= 16'h0000;
            wait_reg <= '0;
            idx_reg <= 1'b0;
            load_after_reg <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            word_reg <= word_next;
            wait_reg <= wait_next;
            idx_reg <= idx_next;
            load_after_reg <= load_after_next;
            start_reg <= start_next;
        end
    end

    // port-line strobes, registered so they never glitch
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fs_n_reg <= dacw_pkg::PIN_IDLE_HIGH;
            ld_n_reg <= dacw_pkg::PIN_IDLE_HIGH;
            clr_n_reg <= dacw_pkg::PIN_IDLE_HIGH;
        end else begin
            fs_n_reg <= fs_n_next;
            ld_n_reg <= ld_n_next;
            clr_n_reg <= clr_n_next;
        end
    end

    assign frame_sync_n_out = fs_n_reg;
    assign output_load_strobe_n_out = ld_n_reg;
    assign output_clear_n_out = clr_n_reg;
    assign serial_shift_clock_out = sclk_w;
    assign serial_data_input_out = sdo_w;

    dacw_tick_gen #(
        .HALF(SCLK_HALF)
    ) u_tick (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .run_in(sh_busy),
        .tick_out(tick)
    );

    dacw_byte_shifter #(
        .LSB_FIRST(LSB_FIRST_SHIFTER)
    ) u_shift (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .start_in(start_reg),
        .byte_in(byte_tx),
        .tick_in(tick),
        .busy_out(sh_busy),
        .done_out(sh_done),
        .fall_out(sh_fall),
        .sclk_out(sclk_w), // [R9]
        .sdo_out(sdo_w) // [R3]
    );

    // chain output comes from the device pin: two flops first
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            chain_s1_reg <= 1'b0;
            chain_s2_reg <= 1'b0;
        end else begin
            chain_s1_reg <= serial_chain_output_in;
            chain_s2_reg <= chain_s1_reg;
        end
    end

    // readback sampled at our falling edge; the device moves it on the
    // rising edge, so a half period covers the two-flop delay
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_reg <= 16'h0000;
            readback_out <= 16'h0000;
            readback_valid_out <= 1'b0;
        end else begin
            readback_valid_out <= 1'b0;
            if (sh_fall) begin
                rx_reg <= {rx_reg[14:0], chain_s2_reg};
            end
            if (state_reg == ST_HOLD && state_next != ST_HOLD) begin
                readback_out <= rx_reg;
                readback_valid_out <= 1'b1;
            end
        end
    end

    // falling edges seen on the pin within the current frame
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fall_cnt_reg <= 5'h00;
        end else if (fs_n_reg) begin
            fall_cnt_reg <= 5'h00;
        end else if (sh_fall) begin
            fall_cnt_reg <= fall_cnt_reg + 5'h01;
        end
    end

    // checks on the pins
    a_clk_in_frame: assert property ( // [R1]
        @(posedge clk_in) disable iff (!rstn_in)
        sclk_w |-> !fs_n_reg)
        else $error("serial clock active outside frame");

    a_clk_idle_low: assert property ( // [R9]
        @(posedge clk_in) disable iff (!rstn_in)
        fs_n_reg |-> !sclk_w)
        else $error("serial clock not idle low");

    a_data_stable: assert property ( // [R3]
        @(posedge clk_in) disable iff (!rstn_in)
        (sclk_w && $past(sclk_w)) |-> $stable(sdo_w))
        else $error("data moved while serial clock high");

    a_sixteen_falls: assert property ( // [R5]
        @(posedge clk_in) disable iff (!rstn_in)
        $rose(fs_n_reg) |-> fall_cnt_reg == 5'd16)
        else $error("frame did not carry sixteen falling edges");

    a_byte_pair: assert property ( // [R4]
        @(posedge clk_in) disable iff (!rstn_in)
        (fall_cnt_reg == 5'd8 && !fs_n_reg) |->
            !fs_n_reg until (fall_cnt_reg == 5'd9))
        else $error("frame sync rose between bytes");

    a_fs_return: assert property ( // [R6]
        @(posedge clk_in) disable iff (!rstn_in)
        (fall_cnt_reg == 5'd16 && !fs_n_reg) |->
            ##[1:FS_RET_MAX] fs_n_reg)
        else $error("frame sync did not return high");

    a_msb_first: assert property ( // [R7]
        @(posedge clk_in) disable iff (!rstn_in)
        ($rose(sclk_w) && fall_cnt_reg == 5'd0) |-> sdo_w == word_reg[15])
        else $error("first bit is not the word msb");

    a_load_no_frame: assert property ( // [R18]
        @(posedge clk_in) disable iff (!rstn_in)
        !ld_n_reg |-> fs_n_reg)
        else $error("load strobe during a frame");

    a_load_width: assert property ( // [R11]
        @(posedge clk_in) disable iff (!rstn_in)
        $fell(ld_n_reg) |-> !ld_n_reg ##1 !ld_n_reg)
        else $error("load strobe pulse too short");

    a_clear_no_frame: assert property ( // [R10]
        @(posedge clk_in) disable iff (!rstn_in)
        !clr_n_reg |-> (fs_n_reg && ld_n_reg))
        else $error("clear overlaps frame or load");

endmodule

// ===== design/dacw_pkg.sv
// package: word layout, timing and command types for the dac word loader
package dacw_pkg;

    // system clock rate in MHz
    localparam int CLK_MHZ = 50;

    // serial word layout
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int CHAN_LSB = 0;
    localparam int CHAN_W = 3;
    localparam int ADDR_BIT = 3;
    localparam int VALUE_LSB = 4;
    localparam int VALUE_W = 12;

    // reset values of the pins
    localparam logic PIN_IDLE_HIGH = 1'b1;
    localparam logic PIN_IDLE_LOW = 1'b0;

    // default serial clock half period in system clocks
    localparam int SCLK_HALF_DEF = 16;

    // timing in ns; counts are least times, so they round up
    localparam int FS_SETUP_NS = 100;
    localparam int BYTE_GAP_NS = 200;
    localparam int FS_HOLD_NS = 100;
    localparam int LOAD_PULSE_NS = 100;
    localparam int CLEAR_PULSE_NS = 100;
    localparam int RECOVER_NS = 100;

    localparam int FS_SETUP_CYC = (FS_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int BYTE_GAP_CYC = (BYTE_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int FS_HOLD_CYC = (FS_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int LOAD_PULSE_CYC = (LOAD_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int CLEAR_PULSE_CYC = (CLEAR_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;

    // width of the wait counter
    localparam int WAIT_W = 8;

    // user command kinds
    typedef enum logic [1:0] {
        DACW_CMD_NOP,
        DACW_CMD_WRITE,
        DACW_CMD_LOAD,
        DACW_CMD_CLEAR
    } dacw_kind_t;

    // one user command
    typedef struct packed {
        dacw_kind_t kind;
        logic load_after;
        logic address;
        logic [CHAN_W-1:0] channel;
        logic [VALUE_W-1:0] value;
    } dacw_cmd_t;

endpackage

// ===== design/dacw_tick_gen.sv
// tick generator: half-period ticks for the serial clock divider
module dacw_tick_gen #(
    parameter int HALF = dacw_pkg::SCLK_HALF_DEF
) (
    input wire logic clk_in,   // system clock
    input wire logic rstn_in,  // async reset, active low
    input wire logic run_in,   // count while high
    output logic tick_out      // one-cycle pulse every HALF clocks
);

    logic [15:0] cnt_reg;

    // counter restarts whenever the shifter is idle, so the first half
    // period of each byte is a full one
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_reg <= 16'h0000;
            tick_out <= 1'b0;
        end else if (!run_in) begin
            cnt_reg <= 16'h0000;
            tick_out <= 1'b0;
        end else if (cnt_reg == 16'(HALF - 1)) begin
            cnt_reg <= 16'h0000;
            tick_out <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
            tick_out <= 1'b0;
        end
    end

endmodule

// ===== dv/dacw_dev_model.sv
// behavioural model of the octal dac serial input, latches and pins
module dacw_dev_model (
    input wire logic frame_sync_n_in,         // frame sync, active low
    input wire logic serial_shift_clock_in,   // serial clock from host
    input wire logic serial_data_input_in,    // serial data from host
    input wire logic output_load_strobe_n_in, // load strobe, active low
    input wire logic output_clear_n_in,       // clear, active low
    input wire logic device_address_pin_in,   // device address pin
    output logic serial_chain_output_out,     // chain output
    output logic [11:0] dac_out [8],          // output latches
    output int last_falls_out,                // falls in the last frame
    output logic load_in_frame_out,           // load seen inside a frame
    output logic clock_outside_out            // clock rise outside a frame
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] shift_reg;
    logic [15:0] word;
    logic [11:0] in_latch [8];
    int bit_cnt;
    int falls;
    // power-up state; the real part has no reset but the clear line
    initial begin
        shift_reg = 16'h0000;
        bit_cnt = 0;
        falls = 0;
        last_falls_out = 0;
        load_in_frame_out = 1'b0;
        clock_outside_out = 1'b0;
        serial_chain_output_out = 1'b0;
        foreach (in_latch[i]) in_latch[i] = 12'h000;
        foreach (dac_out[i]) dac_out[i] = 12'h000;
    end
    // one bit per falling edge, first sixteen of a frame only; counts reset when sync rises
    always @(negedge serial_shift_clock_in or posedge frame_sync_n_in) begin
        if (frame_sync_n_in) begin
            last_falls_out <= falls;
            falls <= 0;
            bit_cnt <= 0;
        end else begin
            falls <= falls + 1;
            if (bit_cnt < 16) begin
                word = {shift_reg[14:0], serial_data_input_in};
                shift_reg <= word;
                bit_cnt <= bit_cnt + 1;
                if (bit_cnt == 15 && word[3] == device_address_pin_in)
                    in_latch[word[2:0]] <= word[15:4];
            end
        end
    end
    // old word leaves on rising edges, frozen once sixteen bits are in
    always @(posedge serial_shift_clock_in) begin
        if (frame_sync_n_in)
            clock_outside_out <= 1'b1;
        else if (bit_cnt < 16)
            serial_chain_output_out <= shift_reg[15];
    end
    // a load inside a frame would publish a half-shifted word
    always @(negedge output_load_strobe_n_in) begin
        if (!frame_sync_n_in)
            load_in_frame_out <= 1'b1;
    end
    // level acting latches, no clock; clear wins over load
    always @* begin
        foreach (dac_out[i]) begin
            if (!output_clear_n_in)
                dac_out[i] = 12'h000;
            else if (!output_load_strobe_n_in)
                dac_out[i] = in_latch[i];
        end
    end
endmodule

// ===== dv/test_dacw_host.sv
// testbench: dac word loader against a behavioural model of the device
module test_dacw_host;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 4;
    localparam int LIMIT = 20000;
    logic clk_in, rstn_in, cmd_valid_in;
    dacw_pkg::dacw_cmd_t cmd_in;
    logic cmd_ready_out, busy_out, readback_valid_out;
    logic [15:0] readback_out;
    logic chain, fs_n, sclk, sdata, load_n, clr_n;
    logic [11:0] dac_val [8];
    logic [11:0] exp_in [8];
    logic [11:0] exp_out [8];
    int last_falls;
    logic load_in_frame, clock_outside;
    logic [15:0] prev_word, rb_word;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;

    dacw_host #(.SCLK_HALF(HALF), .LSB_FIRST_SHIFTER(1'b1)) u_dacw_host (
        .clk_in(clk_in), .rstn_in(rstn_in),
        .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
        .cmd_ready_out(cmd_ready_out), .busy_out(busy_out),
        .readback_out(readback_out),
        .readback_valid_out(readback_valid_out),
        .serial_chain_output_in(chain), .frame_sync_n_out(fs_n),
        .serial_shift_clock_out(sclk), .serial_data_input_out(sdata),
        .output_load_strobe_n_out(load_n), .output_clear_n_out(clr_n));

    dacw_dev_model u_dacw_dev_model (
        .frame_sync_n_in(fs_n), .serial_shift_clock_in(sclk),
        .serial_data_input_in(sdata), .output_load_strobe_n_in(load_n),
        .output_clear_n_in(clr_n), .device_address_pin_in(1'b0),
        .serial_chain_output_out(chain), .dac_out(dac_val),
        .last_falls_out(last_falls), .load_in_frame_out(load_in_frame),
        .clock_outside_out(clock_outside));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // hang guard: a run that overstays counts as a failure
    always @(posedge clk_in) begin
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            finish_test();
        end
    end
    // readback pulse lasts one cycle, so catch it away from the edge
    always @(negedge clk_in) begin
        if (readback_valid_out === 1'b1)
            rb_word = readback_out;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_outs();
        foreach (exp_out[i])
            chk("dac output", {4'h0, exp_out[i]}, {4'h0, dac_val[i]});
    endtask

    // offer one command, then wait for the sequence to end
    task automatic send(input dacw_pkg::dacw_kind_t k, input logic la,
                        input logic adr, input logic [2:0] ch,
                        input logic [11:0] v);
        int n;
        n = 0;
        @(posedge clk_in);
        cmd_in <= '{k, la, adr, ch, v};
        cmd_valid_in <= 1'b1;
        @(posedge clk_in);
        cmd_valid_in <= 1'b0;
        do begin
            @(negedge clk_in);
            n++;
        end while (cmd_ready_out !== 1'b1 && n < 2000);
        chk("ready after command", 16'h1, {15'h0, cmd_ready_out});
    endtask

    task automatic write(input logic la, input logic adr,
                         input logic [2:0] ch, input logic [11:0] v);
        rb_word = 16'hxxxx;
        send(dacw_pkg::DACW_CMD_WRITE, la, adr, ch, v);
        chk("readback word", prev_word, rb_word);
        chk("falls per frame", 16'd16, 16'(last_falls));
        chk("load inside frame", 16'h0, {15'h0, load_in_frame});
        chk("clock outside frame", 16'h0, {15'h0, clock_outside});
        prev_word = {v, adr, ch};
        if (adr == 1'b0)
            exp_in[ch] = v;
        if (la)
            exp_out = exp_in;
        check_outs();
    endtask

    task automatic t_reset();
        @(negedge clk_in);
        chk("idle pins", 16'h002b, {10'h0, cmd_ready_out, busy_out, fs_n,
            sclk, load_n, clr_n});
    endtask

    task automatic t_each();
        for (int c = 0; c < 8; c++)
            write(1'b1, 1'b0, 3'(c), 12'(12'h4c3 + 12'h219 * c));
    endtask

    task automatic t_bulk();
        for (int c = 0; c < 8; c++)
            write(1'b0, 1'b0, 3'(c), 12'(12'hfff - 12'h123 * c));
        send(dacw_pkg::DACW_CMD_LOAD, 1'b0, 1'b0, 3'd0, 12'h000);
        exp_out = exp_in;
        check_outs();
    endtask

    task automatic t_addr();
        write(1'b1, 1'b1, 3'd5, 12'h777);
    endtask

    task automatic t_clear();
        send(dacw_pkg::DACW_CMD_CLEAR, 1'b0, 1'b0, 3'd0, 12'h000);
        foreach (exp_out[i]) exp_out[i] = 12'h000;
        check_outs();
        send(dacw_pkg::DACW_CMD_LOAD, 1'b0, 1'b0, 3'd0, 12'h000);
        exp_out = exp_in;
        check_outs();
        send(dacw_pkg::DACW_CMD_NOP, 1'b1, 1'b0, 3'd2, 12'h0f0);
        check_outs();
    endtask

    initial begin
        rstn_in = 1'b0;
        cmd_valid_in = 1'b0;
        cmd_in = '0;
        prev_word = 16'h0000;
        foreach (exp_in[i]) exp_in[i] = 12'h000;
        exp_out = exp_in;
        repeat (4) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_reset();
        t_each();
        t_bulk();
        t_addr();
        t_clear();
        finish_test();
    end
endmodule
